// file: hdl/ext_mem_pkg.sv
package ext_mem_pkg;

	// Address map, in 14-bit external address space.
	localparam logic [13:0] PM_RAM_LO_MAP0   = 14'h0000;
	localparam logic [13:0] PM_RAM_HI_MAP0   = 14'h01FF;
	localparam logic [13:0] PM_EXT_LO_MAP0   = 14'h0800;
	localparam logic [13:0] PM_RAM_LO_MAP1   = 14'h3800;
	localparam logic [13:0] PM_RAM_HI_MAP1   = 14'h39FF;
	localparam logic [13:0] DM_RAM_LO        = 14'h3800;
	localparam logic [13:0] DM_RAM_HI        = 14'h38FF;
	localparam logic [13:0] DM_CSR_LO        = 14'h3900;
	localparam logic [13:0] DM_CSR_HI        = 14'h3FFF;
	localparam logic [13:0] DM_ZONE_SIZE     = 14'h0C00;
	localparam int          PM_RAM_WORDS     = 512;
	localparam int          DM_ZONES         = 5;

	// Wait states and boot page after reset.
	localparam logic [2:0]  WAIT_PM_RESET    = 3'h7;
	localparam logic [2:0]  WAIT_DM_RESET    = 3'h7;
	localparam logic [2:0]  WAIT_BOOT_RESET  = 3'h3;
	localparam logic [2:0]  BOOT_PAGE_RESET  = 3'h0;

	// Boot image geometry: 1536 bytes per page, three bytes per word.
	localparam logic [10:0] BOOT_PAGE_LAST   = 11'h5FF;
	localparam logic [1:0]  BOOT_BYTES_LAST  = 2'h2;

	// Bus cycle kinds.
	typedef enum logic [1:0] {
		CYC_PM = 2'h0,
		CYC_DM = 2'h1
	} cyc_kind_t;

	// Core access request.
	typedef struct packed {
		logic        valid;
		cyc_kind_t   kind;
		logic        write;
		logic [13:0] addr;
		logic [23:0] wdata;
	} core_req_t;

	// Pins toward external memory and host (strobes active low).
	typedef struct packed {
		logic [13:0] addr;
		logic [23:0] data;
		logic        data_oe;
		logic        code_space_select_n;
		logic        data_space_select_n;
		logic        boot_space_select_n;
		logic        rd_n;
		logic        wr_n;
		logic        pins_oe;
	} ext_pins_t;

	// Idle divider choices: 16, 32, 64, 128.
	localparam logic [7:0]  IDLE_DIV_16      = 8'h10;
	localparam logic [7:0]  IDLE_DIV_32      = 8'h20;
	localparam logic [7:0]  IDLE_DIV_64      = 8'h40;
	localparam logic [7:0]  IDLE_DIV_128     = 8'h80;

endpackage

// file: hdl/pm_ram.sv
`timescale 1ns/100ps
`default_nettype none
// Single-port on-chip program RAM, read data registered.
module pm_ram import ext_mem_pkg::*; (
	// Clock.
	input  wire logic        clk_sys_in,
	// Port.
	input  wire logic        we_in,
	input  wire logic [8:0]  addr_in,
	input  wire logic [23:0] wdata_in,
	output var  logic [23:0] rdata_out
);
	logic [23:0] mem [PM_RAM_WORDS];

	// No reset on the array, so it maps onto plain RAM.
	always_ff @(posedge clk_sys_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
		rdata_out <= mem[addr_in];
	end
endmodule // pm_ram
`default_nettype wire

// file: hdl/ext_mem_boot.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Map low: on-chip code 0x0000, external from 0x0800.
// - Map low: boot starts when reset releases.
// - Map high: external from 0, RAM 0x3800-0x39FF.
// - 14-bit address; data words on D23..D8.
// - Data select with read or write strobe.
// - Data RAM 0x3800, registers 0x3900-0x3FFF.
// - Five external data zones, seven waits.
// - Boot pages 1536 bytes, packed into 24-bit words.
// - Three-bit page select, software boot force bit.
// - Boot waits 0-7, three after reset.
// - Boot select plus read, bytes on D15..D8.
// - Bus granted during boot after current byte.
// - Idle bus request: float pins, grant next cycle.
// - Go mode keeps halt low while granted from idle; no access is served until release.
// - Busy bus request: grant after access ends.
// - Request released: drop grant, drive, resume.
// - Requests serviced always, even in reset.
// - Idle waits for interrupt, then continues.
// - Divided idle slows clocks by 16..128.
// - Wake within divisor cycles of interrupt.
// - Code select on external program memory accesses.
// - Code waits 0-7, seven after reset.
module ext_mem_boot import ext_mem_pkg::*; (
	// Clock and reset.
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// Straps and configuration.
	input  wire logic        memory_map_select_in,
	input  wire logic [2:0]  boot_page_in,
	input  wire logic        boot_force_in,
	input  wire logic        go_mode_in,
	input  wire logic [2:0]  wait_pm_in,
	input  wire logic [2:0]  wait_boot_in,
	input  wire logic [14:0] wait_dm_zones_in,
	input  wire logic        wait_cfg_we_in,
	// Core access request.
	input  wire core_req_t   core_req_in,
	output logic             core_ack_out,
	output logic [23:0]      core_rdata_out,
	output logic             core_halt_out,
	output logic             booting_out,
	// Idle control.
	input  wire logic        idle_in,
	input  wire logic [7:0]  idle_div_in,
	input  wire logic        irq_in,
	output logic             idle_out,
	output logic             clk_en_out,
	output logic             output_clock_out,
	// External pins.
	input  wire logic [23:0] data_in,
	output ext_pins_t        pins_out,
	input  wire logic        bus_request_n_in,
	output logic             bus_grant_n_out
);

	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_ACC   = 5'b00010,
		ST_BOOT  = 5'b00100,
		ST_GRANT = 5'b01000,
		ST_SLEEP = 5'b10000
	} st_t;

	typedef struct packed {
		st_t         st;
		logic [2:0]  wcnt;
		logic        acc_wr;
		logic        acc_int;
		logic [1:0]  bsel;
		logic [10:0] bcnt;
		logic [23:0] bword;
		logic [2:0]  page;
		logic        boot_pend;
		logic        boot_rd;
		logic [2:0]  w_pm;
		logic [2:0]  w_boot;
		logic [14:0] w_dm;
		logic [7:0]  div;
		logic [7:0]  dcnt;
		logic        clk_en;
		logic        oclk;
		logic        ack;
		logic [23:0] rdata;
		logic        booting;
		ext_pins_t   pins;
		logic        grant_n;
		logic        sleep_div;
		logic        go_run;
		logic        acc_dm;
		logic        halt;
		logic        sleeping;
	} state_t;

	state_t s_q, s_d;

	logic        ram_we;
	logic [8:0]  ram_addr;
	logic [23:0] ram_wdata;
	logic [23:0] ram_rdata;
	logic        dm_we;
	logic [23:0] dm_rdata;
	logic        grant_n_q;
	logic        oe_q;

	pm_ram u_ram (
		.clk_sys_in (clk_sys_in),
		.we_in      (ram_we),
		.addr_in    (ram_addr),
		.wdata_in   (ram_wdata),
		.rdata_out  (ram_rdata)
	);

	// On-chip data RAM, kept apart so data stores never touch code.
	pm_ram u_dm_ram (
		.clk_sys_in (clk_sys_in),
		.we_in      (dm_we),
		.addr_in    ({1'b0, core_req_in.addr[7:0]}),
		.wdata_in   (core_req_in.wdata),
		.rdata_out  (dm_rdata)
	);

	// Is a program address on-chip under the current map?
	function automatic logic pm_on_chip(input logic memory_map_select, input logic [13:0] a);
		if (memory_map_select) begin
			pm_on_chip = (a >= PM_RAM_LO_MAP1) && (a <= PM_RAM_HI_MAP1);
		end else begin
			pm_on_chip = a < PM_EXT_LO_MAP0;
		end
	endfunction

	// Data zone wait select; 3K zones from address 0, everything above zone 4 uses zone 4.
	function automatic logic [2:0] dm_wait(input logic [14:0] w, input logic [13:0] a);
		logic [2:0] z;
		z = 3'(a / DM_ZONE_SIZE);
		if (z > 3'h4) begin
			z = 3'h4;
		end
		dm_wait = w[z*3 +: 3];
	endfunction

	logic req_bus;
	assign req_bus = !bus_request_n_in;

	// Only the 256-word data RAM takes stores; the register region does not.
	assign dm_we = s_q.st == ST_ACC && s_q.acc_int && s_q.acc_wr && s_q.acc_dm
		&& core_req_in.addr <= DM_RAM_HI;

	// Program RAM port: boot writes win over core access.
	always_comb begin
		ram_we    = 1'b0;
		ram_addr  = core_req_in.addr[8:0];
		ram_wdata = core_req_in.wdata;
		if (s_q.st == ST_BOOT && s_q.bsel == BOOT_BYTES_LAST && s_q.wcnt == 3'h0
			&& s_q.boot_rd) begin
			ram_we    = 1'b1;
			ram_addr  = 9'(s_q.bcnt / 11'h3);
			ram_wdata = {s_q.bword[15:0], data_in[15:8]};
		end else if (s_q.st == ST_ACC && s_q.acc_int && s_q.acc_wr && !s_q.acc_dm) begin
			ram_we    = 1'b1;
		end
	end

	// Next-state logic for the whole interface.
	always_comb begin
		s_d        = s_q;
		s_d.ack    = 1'b0;
		s_d.oclk   = s_q.clk_en ? ~s_q.oclk : s_q.oclk;
		s_d.clk_en = 1'b1;
		if (wait_cfg_we_in) begin
			s_d.w_pm   = wait_pm_in;
			s_d.w_boot = wait_boot_in;
			s_d.w_dm   = wait_dm_zones_in;
		end
		if (boot_force_in) begin
			s_d.boot_pend = 1'b1;
			s_d.page      = boot_page_in;
		end
		// With the map strap high a pending boot is dropped, not run.
		if (s_q.st == ST_IDLE && memory_map_select_in && !boot_force_in) begin
			s_d.boot_pend = 1'b0;
		end
		case (s_q.st)
			ST_IDLE: begin
				s_d.pins.rd_n = 1'b1;
				s_d.pins.wr_n = 1'b1;
				s_d.pins.code_space_select_n = 1'b1;
				s_d.pins.data_space_select_n = 1'b1;
				s_d.pins.boot_space_select_n = 1'b1;
				s_d.pins.data_oe = 1'b0;
				if (req_bus) begin
					s_d.st       = ST_GRANT;
					s_d.grant_n  = 1'b0;
					s_d.pins.pins_oe = 1'b0;
					s_d.go_run   = go_mode_in;
				end else if (s_q.boot_pend && !memory_map_select_in) begin
					s_d.st      = ST_BOOT;
					s_d.booting = 1'b1;
					s_d.bcnt    = 11'h000;
					s_d.bsel    = 2'h0;
					s_d.boot_pend = 1'b0;
				end else if (idle_in) begin
					s_d.st  = ST_SLEEP;
					s_d.div = idle_div_in;
					s_d.sleep_div = idle_div_in != 8'h00;
					s_d.dcnt = 8'h00;
				end else if (core_req_in.valid) begin
					s_d.acc_wr  = core_req_in.write;
					s_d.acc_dm  = core_req_in.kind == CYC_DM;
					s_d.acc_int = (core_req_in.kind == CYC_PM)
						? pm_on_chip(memory_map_select_in, core_req_in.addr)
						: (core_req_in.addr >= DM_RAM_LO);
					s_d.st = ST_ACC;
					s_d.pins.addr = core_req_in.addr;
					if (core_req_in.kind == CYC_PM) begin
						s_d.wcnt = s_q.w_pm;
					end else begin
						s_d.wcnt = dm_wait(s_q.w_dm, core_req_in.addr);
					end
					if (!s_d.acc_int) begin
						s_d.pins.code_space_select_n = core_req_in.kind != CYC_PM;
						s_d.pins.data_space_select_n = core_req_in.kind != CYC_DM;
						s_d.pins.rd_n = core_req_in.write;
						s_d.pins.wr_n = !core_req_in.write;
						s_d.pins.data_oe = core_req_in.write;
						s_d.pins.data = (core_req_in.kind == CYC_DM)
							? {core_req_in.wdata[15:0], 8'h00} : core_req_in.wdata;
					end else begin
						s_d.wcnt = 3'h0;
					end
				end
			end
			ST_ACC: begin
				// A pending request waits until the access finishes.
				if (s_q.wcnt != 3'h0) begin
					s_d.wcnt = s_q.wcnt - 3'h1;
				end else begin
					s_d.ack = 1'b1;
					s_d.rdata = s_q.acc_int
						? (s_q.acc_dm ? {8'h00, dm_rdata[15:0]} : ram_rdata)
						: (s_q.pins.code_space_select_n ? {8'h00, data_in[23:8]} : data_in);
					s_d.st = ST_IDLE;
				end
			end
			ST_BOOT: begin
				// Byte read: select, strobe, page on D23, D22 and A13.
				s_d.pins.boot_space_select_n = 1'b0;
				s_d.pins.rd_n    = 1'b0;
				s_d.pins.data_oe = 1'b1;
				s_d.pins.data    = {s_q.page[2:1], 22'h000000};
				s_d.pins.addr    = {s_q.page[0], 2'h0, s_q.bcnt};
				if (!s_q.boot_rd) begin
					s_d.boot_rd = 1'b1;
					s_d.wcnt    = s_q.w_boot;
				end else if (s_q.wcnt != 3'h0) begin
					s_d.wcnt = s_q.wcnt - 3'h1;
				end else begin
					s_d.boot_rd = 1'b0;
					s_d.bword = {s_q.bword[15:0], data_in[15:8]};
					s_d.bsel  = (s_q.bsel == BOOT_BYTES_LAST) ? 2'h0 : s_q.bsel + 2'h1;
					s_d.bcnt  = s_q.bcnt + 11'h001;
					s_d.pins.boot_space_select_n = 1'b1;
					s_d.pins.rd_n = 1'b1;
					if (s_q.bcnt == BOOT_PAGE_LAST) begin
						s_d.st = ST_IDLE;
						s_d.booting = 1'b0;
					end else if (req_bus) begin
						s_d.st = ST_GRANT;
						s_d.grant_n = 1'b0;
						s_d.pins.pins_oe = 1'b0;
					end
				end
			end
			ST_GRANT: begin
				if (!req_bus) begin
					s_d.grant_n = 1'b1;
					s_d.pins.pins_oe = 1'b1;
					s_d.go_run = 1'b0;
					s_d.st = s_q.booting ? ST_BOOT : ST_IDLE;
				end
			end
			ST_SLEEP: begin
				// Divided clock enable; wake on an enable edge.
				s_d.dcnt = (s_q.dcnt + 8'h01 >= s_q.div) ? 8'h00 : s_q.dcnt + 8'h01;
				s_d.clk_en = !s_q.sleep_div || (s_q.dcnt == 8'h00);
				if (irq_in && s_d.clk_en) begin
					s_d.st = ST_IDLE;
					s_d.sleep_div = 1'b0;
				end else if (req_bus) begin
					s_d.grant_n = 1'b0;
					s_d.pins.pins_oe = 1'b0;
				end else begin
					s_d.grant_n = 1'b1;
					s_d.pins.pins_oe = 1'b1;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
		if (s_q.st == ST_SLEEP && s_d.st != ST_SLEEP) begin
			s_d.grant_n = 1'b1;
			s_d.pins.pins_oe = 1'b1;
		end
		// Status levels are registered so that the outputs come from flops.
		s_d.halt     = (s_d.st == ST_GRANT && !s_d.go_run) || s_d.st == ST_SLEEP;
		s_d.sleeping = s_d.st == ST_SLEEP;
	end

	// Register all state; the map strap is not latched, it is read live on every clock.
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.w_pm <= WAIT_PM_RESET;
			s_q.w_boot <= WAIT_BOOT_RESET;
			s_q.w_dm <= {DM_ZONES{WAIT_DM_RESET}};
			s_q.page <= BOOT_PAGE_RESET;
			s_q.boot_pend <= 1'b1;
			s_q.pins.code_space_select_n <= 1'b1;
			s_q.pins.data_space_select_n <= 1'b1;
			s_q.pins.boot_space_select_n <= 1'b1;
			s_q.pins.rd_n <= 1'b1;
			s_q.pins.wr_n <= 1'b1;
			s_q.pins.pins_oe <= 1'b1;
			s_q.grant_n <= 1'b1;
			s_q.clk_en <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Grant and drive enable follow the request even in reset, so this pair has
	// no asynchronous reset; it is valid from the first clock edge of reset.
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			grant_n_q <= bus_request_n_in;
			oe_q      <= bus_request_n_in;
		end else begin
			grant_n_q <= s_d.grant_n;
			oe_q      <= s_d.pins.pins_oe;
		end
	end

	assign core_ack_out     = s_q.ack;
	assign core_rdata_out   = s_q.rdata;
	assign core_halt_out    = s_q.halt;
	assign booting_out      = s_q.booting;
	assign idle_out         = s_q.sleeping;
	assign clk_en_out       = s_q.clk_en;
	assign output_clock_out = s_q.oclk;
	assign bus_grant_n_out  = grant_n_q;

	// Pin bundle with the drive enable taken from the reset-transparent flop.
	always_comb begin
		pins_out         = s_q.pins;
		pins_out.pins_oe = oe_q;
	end

	a_grant_float: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!bus_grant_n_out |-> !pins_out.pins_oe) else $error("grant with pins driven");
	a_idle_grant: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_q.st == ST_IDLE && req_bus |=> !bus_grant_n_out) else $error("late grant");
	a_acc_grant: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_q.st == ST_ACC && req_bus |-> ##[1:9] !bus_grant_n_out || !req_bus)
		else $error("grant after access too late");
	a_release: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_q.st == ST_GRANT && !req_bus |=> bus_grant_n_out && pins_out.pins_oe)
		else $error("grant not released");
	a_boot_sel: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!pins_out.boot_space_select_n |-> pins_out.code_space_select_n
		&& pins_out.data_space_select_n) else $error("boot select overlaps");
	a_dm_strobe: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!pins_out.data_space_select_n |-> pins_out.rd_n != pins_out.wr_n)
		else $error("data select without one strobe");
	a_pm_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$rose(s_q.st == ST_ACC) && !s_q.pins.code_space_select_n |-> s_q.wcnt == s_q.w_pm)
		else $error("wait count too large");
	a_wake: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_q.st == ST_SLEEP && irq_in |-> ##[0:128] s_q.st != ST_SLEEP || !irq_in)
		else $error("wake too slow");
	c_boot: cover property (@(posedge clk_sys_in) $fell(s_q.booting));
	c_grant: cover property (@(posedge clk_sys_in) $fell(bus_grant_n_out));
	c_sleep: cover property (@(posedge clk_sys_in) $fell(idle_out));

endmodule // ext_mem_boot
`default_nettype wire

// file: sim/ext_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// External memories and boot store as seen from the device pins.
module ext_mem_model import ext_mem_pkg::*; (
	// Clock.
	input  wire logic        clk_sys_in,
	// Device pins.
	input  wire ext_pins_t   pins_in,
	output logic [23:0]      data_out
);
	logic [23:0] mem [0:255];
	logic [23:0] last_q = 24'h0;
	logic [7:0]  boot_byte;
	// Preset words so that a read of an unwritten place is still predictable.
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = {i[7:0], ~i[7:0], 8'h3C};
		end
	end
	// The boot byte depends on the byte address and the page on A13, D23, D22.
	assign boot_byte = pins_in.addr[7:0] ^ {pins_in.data[23:22], pins_in.addr[13], 5'h15};
	// Lines nobody reads toggle every cycle, so a stale value can never pass.
	always_comb begin
		data_out = ~last_q;
		if (pins_in.pins_oe && !pins_in.rd_n && !pins_in.boot_space_select_n) begin
			data_out[15:8] = boot_byte;
		end else if (pins_in.pins_oe && !pins_in.rd_n) begin
			data_out = mem[pins_in.addr[7:0]];
		end
	end
	// Stores land on the rising edge while the write strobe is low.
	always_ff @(posedge clk_sys_in) begin
		last_q <= data_out;
		if (pins_in.pins_oe && !pins_in.wr_n) begin
			mem[pins_in.addr[7:0]] <= pins_in.data;
		end
	end
endmodule // ext_mem_model
`default_nettype wire

// file: sim/test_ext_mem_boot.sv
`timescale 1ns/100ps
`default_nettype none
// Self-checking bench for the external memory and boot interface.
module test_ext_mem_boot import ext_mem_pkg::*;;
	logic        clk_sys_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic        map_sel    = 1'b0;
	logic [2:0]  page       = 3'h0;
	logic        force_boot = 1'b0;
	logic [2:0]  wait_pm    = 3'h7;
	logic [14:0] wait_dm    = 15'h7FFF;
	logic        cfg_we     = 1'b0;
	core_req_t   req        = '0;
	logic        idle_req   = 1'b0;
	logic [7:0]  idle_div   = 8'h10;
	logic        irq        = 1'b0;
	logic        br_n       = 1'b1;
	logic [23:0] ext_data;
	logic        ack, halt, booting, idle_o, clk_en, bg_n;
	logic [23:0] rdata, wr_pins;
	ext_pins_t   pins;
	logic [2:0]  seen;
	int          lat, mismatches = 0, total_checks = 0;

	ext_mem_boot u_ext_mem_boot (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.memory_map_select_in(map_sel), .boot_page_in(page), .boot_force_in(force_boot),
		.go_mode_in(1'b0), .wait_pm_in(wait_pm), .wait_boot_in(3'h3),
		.wait_dm_zones_in(wait_dm), .wait_cfg_we_in(cfg_we), .core_req_in(req),
		.core_ack_out(ack), .core_rdata_out(rdata), .core_halt_out(halt),
		.booting_out(booting), .idle_in(idle_req), .idle_div_in(idle_div), .irq_in(irq),
		.idle_out(idle_o), .clk_en_out(clk_en), .output_clock_out(), .data_in(ext_data),
		.pins_out(pins), .bus_request_n_in(br_n), .bus_grant_n_out(bg_n));
	ext_mem_model u_ext_mem_model (.clk_sys_in(clk_sys_in), .pins_in(pins), .data_out(ext_data));

	// Clock at 20 MHz.
	initial begin
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	// Inputs change 5 ns after an edge, so outputs are settled when read.
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_in);
		#5;
	endtask
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	function automatic logic [7:0] bb(input logic [2:0] p, input logic [7:0] a);
		return a ^ {p, 5'h15};
	endfunction
	// One core access; lat counts edges from request to acknowledge, seen the pins.
	task automatic access(input cyc_kind_t k, input logic w, input logic [13:0] a,
		input logic [23:0] d);
		req = '{valid: 1'b1, kind: k, write: w, addr: a, wdata: d};
		seen = 3'h0;
		lat = 0;
		for (int i = 0; i < 40 && ack !== 1'b1; i++) begin
			step(1);
			lat++;
			seen |= {!pins.code_space_select_n, !pins.data_space_select_n && !pins.rd_n,
				!pins.data_space_select_n && !pins.wr_n};
			if (!pins.wr_n) begin
				wr_pins = pins.data;
			end
		end
		req.valid = 1'b0;
		step(1);
	endtask
	// Boot of one page, interrupted once by a bus request.
	task automatic t_boot(input logic [2:0] p);
		int n;
		for (n = 0; n < 50 && !(pins.boot_space_select_n === 1'b0 && pins.rd_n === 1'b0); n++) begin
			step(1);
		end
		check("boot page pins", {21'h0, p}, {21'h0, pins.data[23:22], pins.addr[13]});
		br_n = 1'b0;
		for (n = 0; n < 30 && bg_n !== 1'b0; n++) begin
			step(1);
		end
		check("boot grant", 24'h2, {22'h0, booting, pins.pins_oe});
		step(5);
		br_n = 1'b1;
		step(2);
		check("boot grant release", 24'h1, {23'h0, bg_n});
		for (n = 0; n < 30000 && booting !== 1'b0; n++) begin
			step(1);
		end
		access(CYC_PM, 1'b0, 14'h0000, 24'h0);
		check("boot word 0", {bb(p, 8'h00), bb(p, 8'h01), bb(p, 8'h02)}, rdata);
		check("internal code lat", 24'h2, {21'h0, seen} | 24'(lat));
		access(CYC_PM, 1'b0, 14'h01FF, 24'h0);
		check("boot word 511", {bb(p, 8'hFD), bb(p, 8'hFE), bb(p, 8'hFF)}, rdata);
		$display("boot test of page %0d done", p);
	endtask
	// Request while idle, then one that arrives during a slow data access.
	task automatic t_grant();
		int n;
		logic got;
		br_n = 1'b0;
		step(1);
		check("idle grant", 24'h1, {21'h0, bg_n, pins.pins_oe, halt});
		step(3);
		br_n = 1'b1;
		step(1);
		check("idle release", 24'h6, {21'h0, bg_n, pins.pins_oe, halt});
		req = '{valid: 1'b1, kind: CYC_DM, write: 1'b0, addr: 14'h3000, wdata: 24'h0};
		step(2);
		br_n = 1'b0;
		got = 1'b0;
		for (n = 0; n < 12 && bg_n !== 1'b0; n++) begin
			got |= ack;
			req.valid = req.valid && !ack;
			step(1);
		end
		got |= ack;
		req.valid = 1'b0;
		check("busy grant delay", 24'h3, {22'h0, got, n >= 5 && n <= 9});
		check("busy grant float", 24'h0, {23'h0, pins.pins_oe});
		br_n = 1'b1;
		step(2);
		$display("bus grant test done");
	endtask
	// Data zones, internal regions and program memory wait states.
	task automatic t_mem();
		access(CYC_PM, 1'b0, 14'h0800, 24'h0);
		check("code read", 24'h00FF3C, rdata);
		check("code default wait", 24'h9, 24'(lat));
		check("code select", 24'h4, {21'h0, seen});
		access(CYC_DM, 1'b1, 14'h3000, 24'h005A5A);
		check("zone default wait", 24'h9, 24'(lat));
		check("data write strobe", 24'h1, {21'h0, seen});
		check("data lines", 24'h5A5A, {8'h0, wr_pins[23:8]});
		wait_dm = {3'h7, 3'h7, 3'h7, 3'h5, 3'h0};
		wait_pm = 3'h1;
		cfg_we = 1'b1;
		step(1);
		cfg_we = 1'b0;
		step(1);
		access(CYC_DM, 1'b1, 14'h0BFF, 24'h00C3A5);
		check("zone 0 wait", 24'h2, 24'(lat));
		access(CYC_DM, 1'b0, 14'h0BFF, 24'h0);
		check("data read strobe", 24'h2, {21'h0, seen});
		check("zone 0 read", 24'h00C3A5, rdata);
		access(CYC_DM, 1'b0, 14'h0C00, 24'h0);
		check("zone 1 wait", 24'h7, 24'(lat));
		check("zone 1 read", 24'h005A5A, rdata);
		access(CYC_DM, 1'b1, 14'h3800, 24'h001234);
		access(CYC_DM, 1'b0, 14'h3800, 24'h0);
		check("data ram", 24'h001234, rdata | {seen, 21'h0});
		access(CYC_DM, 1'b0, 14'h3900, 24'h0);
		check("register region pins", 24'h0, {21'h0, seen});
		access(CYC_PM, 1'b0, 14'h0801, 24'h0);
		check("code set wait", 24'h3, 24'(lat));
		check("code read 1", 24'h01FE3C, rdata);
		$display("memory map test done");
	endtask
	// Each divisor slows the enable and bounds the wake-up time.
	task automatic t_idle();
		logic [7:0] divs [4];
		int cnt, n;
		divs = '{IDLE_DIV_16, IDLE_DIV_32, IDLE_DIV_64, IDLE_DIV_128};
		for (int d = 0; d < 4; d++) begin
			idle_div = divs[d];
			idle_req = 1'b1;
			step(1);
			idle_req = 1'b0;
			step(2);
			check("idle entered", 24'h1, {23'h0, idle_o});
			cnt = 0;
			for (int i = 0; i < 256; i++) begin
				step(1);
				cnt += int'(clk_en === 1'b1);
			end
			check("divided enables", 24'(256 / divs[d]), 24'(cnt));
			irq = 1'b1;
			for (n = 0; n < 200 && idle_o !== 1'b0; n++) begin
				step(1);
			end
			irq = 1'b0;
			check("wake bound", 24'h1, {23'h0, n <= divs[d] && idle_o === 1'b0});
			step(4);
		end
		$display("idle test done");
	endtask
	// Map select high: no boot, program RAM moves to 0x3800.
	task automatic t_map1();
		rst_in = 1'b1;
		map_sel = 1'b1;
		step(2);
		rst_in = 1'b0;
		step(40);
		check("no boot", 24'h1, {22'h0, booting, pins.boot_space_select_n});
		access(CYC_PM, 1'b0, 14'h0000, 24'h0);
		check("external at 0", 24'h4, {21'h0, seen});
		access(CYC_PM, 1'b1, 14'h3800, 24'h123456);
		access(CYC_PM, 1'b0, 14'h3800, 24'h0);
		check("ram at 0x3800", 24'h123456, rdata | {seen, 21'h0});
		$display("map high test done");
	endtask
	// Reset with a bus request inside it, then the tests in order.
	initial begin
		step(4);
		br_n = 1'b0;
		step(2);
		check("grant in reset", 24'h0, {22'h0, bg_n, pins.pins_oe});
		br_n = 1'b1;
		step(2);
		check("reset pins", 24'h3F, {18'h0, bg_n, pins.code_space_select_n,
			pins.data_space_select_n, pins.boot_space_select_n, pins.rd_n, pins.wr_n});
		step(4);
		rst_in = 1'b0;
		step(3);
		check("boot after reset", 24'h1, {23'h0, booting});
		t_boot(3'h0);
		t_grant();
		t_mem();
		page = 3'h5;
		force_boot = 1'b1;
		step(1);
		force_boot = 1'b0;
		t_boot(3'h5);
		t_idle();
		t_map1();
		complete_run();
	end
	// Watchdog well beyond two boots and the other tests.
	initial begin
		repeat (90000) @(posedge clk_sys_in);
		mismatches++;
		$display("[ERR] watchdog expected finish seen hang");
		complete_run();
	end
endmodule // test_ext_mem_boot
`default_nettype wire
